/* File: design/ltsc_pkg.sv */
// Types and constants for the line transceiver status/config block.
// Assumes a single 200 MHz register-port clock domain.
package ltsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          LTSC_ADDR_W        = 2;
    localparam logic [1:0]  LTSC_ADDR_STATUS   = 2'h0;
    localparam logic [1:0]  LTSC_ADDR_LINE_CFG = 2'h1;
    localparam logic [7:0]  LTSC_LINE_CFG_RST  = 8'h00;
    localparam logic [7:0]  LTSC_READ_ZERO     = 8'h00;

    // ------------------------------------------------------------
    // Serial frame layout: header byte then data byte, MSB first
    // ------------------------------------------------------------
    localparam int          LTSC_FRAME_BITS    = 16;
    localparam logic [4:0]  LTSC_FRAME_CNT     = 5'h10;
    localparam logic [4:0]  LTSC_HDR_LAST      = 5'h07;
    localparam int          LTSC_WR_POS        = 15;
    localparam int          LTSC_ADDR_LSB      = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic receive_filter_select;
        logic fast_slew_select;
        logic line_sink_source_select;
        logic line_push_pull_select;
        logic line_driver_force_enable;
        logic line_soft_value;
        logic line_receiver_disable;
        logic line_current_sink_enable;
    } ltsc_line_cfg_t;

    // Comparator outputs from the analog front end
    typedef struct packed {
        logic line_high;
        logic aux_high;
        logic line_fault;
        logic low_rail_uv;
        logic supply_uv;
        logic temp_hot;
        logic temp_cool;
    } ltsc_mon_t;

    typedef struct packed {
        logic wake_irq;
        logic aux_fault_irq;
        logic input_pin_level;
        logic inverted_line_level;
        logic line_fault_irq;
        logic low_rail_uv_irq;
        logic supply_uv_irq;
        logic overtemp_irq;
    } ltsc_status_t;

    typedef struct packed {
        logic line_fault_flag;
        logic supply_uv_flag;
        logic overtemp_flag;
        logic low_rail_uv_enable;
    } ltsc_mode_flags_t;

    localparam int LTSC_MON_W  = $bits(ltsc_mon_t);
    localparam int LTSC_PIN_W  = LTSC_MON_W + 6;

endpackage : ltsc_pkg

/* File: design/ltsc_core.sv */
// Status flags and line configuration register behind the serial port.
// Assumes comparator levels and MCU pins are asynchronous to i_clk and
// that the serial clock is well below a quarter of i_clk.
`timescale 1ns/10ps
`default_nettype none

module ltsc_core
    import ltsc_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_spi_cs_n,
    input  wire logic             i_spi_sclk,
    input  wire logic             i_spi_sdi,
    output var  logic             o_spi_sdo,
    output var  logic             o_spi_sdo_oe,
    input  wire logic             i_driver_enable_pin,
    input  wire logic             i_transmit_input_a,
    input  wire logic             i_transmit_input_b,
    input  wire ltsc_mon_t        i_mon,
    input  wire logic             i_mode_wr,
    input  wire logic             i_mode_uv_enable,
    output var  ltsc_mode_flags_t o_mode_flags,
    output var  ltsc_line_cfg_t   o_line_cfg,
    output var  logic             o_line_out,
    output var  logic             o_line_oe,
    output var  logic             o_line_receive_out,
    output var  logic             o_input_level_out,
    output var  logic             o_undervoltage_out,
    output var  logic             o_interrupt_out_n
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Chip select idles high so reset never looks like a frame
    localparam logic [LTSC_PIN_W-1:0] SYNC_RST =
        {1'b1, {(LTSC_PIN_W-1){1'b0}}};

    logic [LTSC_PIN_W-1:0] sync1_ff;
    logic [LTSC_PIN_W-1:0] sync2_ff;
    logic                  cs_n;
    logic                  sclk;
    logic                  sdi;
    logic                  driver_enable_pin;
    logic                  tx_a;
    logic                  tx_b;
    ltsc_mon_t             mon;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= {i_spi_cs_n, i_spi_sclk, i_spi_sdi,
                         i_driver_enable_pin, i_transmit_input_a,
                         i_transmit_input_b, i_mon};
            sync2_ff <= sync1_ff;
        end
    end

    assign {cs_n, sclk, sdi, driver_enable_pin, tx_a, tx_b, mon} = sync2_ff;

    // ------------------------------------------------------------
    // Serial register port
    // ------------------------------------------------------------
    logic                       cs_n_d_ff;
    logic                       sclk_d_ff;
    logic [4:0]                 bit_cnt_ff;
    logic [LTSC_FRAME_BITS-1:0] shift_in_ff;
    logic [7:0]                 shift_out_ff;
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic                       hdr_done;
    logic [7:0]                 hdr;
    logic                       rd_status;
    logic                       frame_end;
    logic [7:0]                 rd_data;
    ltsc_line_cfg_t             cfg_ff;
    ltsc_status_t               status;

    assign sclk_rise = ~cs_n & sclk & ~sclk_d_ff;
    assign sclk_fall = ~cs_n & ~sclk & sclk_d_ff;
    assign hdr_done  = sclk_rise && (bit_cnt_ff == LTSC_HDR_LAST);
    assign hdr       = {shift_in_ff[6:0], sdi};
    assign rd_status = hdr_done && !hdr[7]
                       && (hdr[LTSC_ADDR_W-1:0] == LTSC_ADDR_STATUS);
    assign frame_end = cs_n & ~cs_n_d_ff;

    always_comb begin
        if (hdr[LTSC_ADDR_W-1:0] == LTSC_ADDR_STATUS) begin
            rd_data = status;
        end else if (hdr[LTSC_ADDR_W-1:0] == LTSC_ADDR_LINE_CFG) begin
            rd_data = cfg_ff;
        end else begin
            rd_data = LTSC_READ_ZERO;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_n_d_ff <= 1'b1;
            sclk_d_ff <= 1'b0;
        end else begin
            cs_n_d_ff <= cs_n;
            sclk_d_ff <= sclk;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_cnt_ff  <= '0;
            shift_in_ff <= '0;
        end else if (cs_n) begin
            bit_cnt_ff  <= '0;
        end else if (sclk_rise) begin
            shift_in_ff <= {shift_in_ff[LTSC_FRAME_BITS-2:0], sdi};
            if (bit_cnt_ff != LTSC_FRAME_CNT) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
        end
    end

    // Read data is snapshotted at header end, so clearing cannot tear it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_out_ff <= '0;
            o_spi_sdo    <= 1'b0;
            o_spi_sdo_oe <= 1'b0;
        end else begin
            o_spi_sdo_oe <= ~cs_n;
            if (hdr_done) begin
                shift_out_ff <= rd_data;
            end else if (sclk_fall) begin
                o_spi_sdo    <= shift_out_ff[7];
                shift_out_ff <= {shift_out_ff[6:0], 1'b0};
            end
        end
    end

    // Writes commit only on a complete frame at chip-select release
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_ff <= LTSC_LINE_CFG_RST;
        end else if (frame_end && bit_cnt_ff == LTSC_FRAME_CNT
                     && shift_in_ff[LTSC_WR_POS]
                     && shift_in_ff[LTSC_ADDR_LSB +: LTSC_ADDR_W]
                        == LTSC_ADDR_LINE_CFG) begin
            cfg_ff <= shift_in_ff[7:0];
        end
    end

    // ------------------------------------------------------------
    // Alarm flags; a set in the clearing cycle wins
    // ------------------------------------------------------------
    logic lf_irq_ff;
    logic lr_irq_ff;
    logic su_irq_ff;
    logic ot_irq_ff;
    logic ot_flag_ff;
    logic lr_uv_d_ff;
    logic su_uv_d_ff;
    logic ot_flag_d_ff;
    logic lr_en_ff;
    logic lr_rise;
    logic su_rise;
    logic ot_rise;

    assign lr_rise = mon.low_rail_uv & ~lr_uv_d_ff;
    assign su_rise = mon.supply_uv & ~su_uv_d_ff;
    assign ot_rise = ot_flag_ff & ~ot_flag_d_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lr_uv_d_ff   <= 1'b0;
            su_uv_d_ff   <= 1'b0;
            ot_flag_d_ff <= 1'b0;
        end else begin
            lr_uv_d_ff   <= mon.low_rail_uv;
            su_uv_d_ff   <= mon.supply_uv;
            ot_flag_d_ff <= ot_flag_ff;
        end
    end

    // Hysteresis keeps the warning from rearming while still warm
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ot_flag_ff <= 1'b0;
        end else if (mon.temp_hot) begin
            ot_flag_ff <= 1'b1;
        end else if (mon.temp_cool) begin
            ot_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lf_irq_ff <= 1'b0;
            lr_irq_ff <= 1'b0;
            su_irq_ff <= 1'b0;
            ot_irq_ff <= 1'b0;
        end else begin
            // Level set: a lasting fault re-flags right after a read
            lf_irq_ff <= mon.line_fault
                         | (lf_irq_ff & ~rd_status);
            lr_irq_ff <= lr_rise | (lr_irq_ff & ~rd_status);
            su_irq_ff <= su_rise | (su_irq_ff & ~rd_status);
            ot_irq_ff <= ot_rise | (ot_irq_ff & ~rd_status);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lr_en_ff <= 1'b0;
        end else if (lr_rise) begin
            lr_en_ff <= 1'b1;
        end else if (i_mode_wr) begin
            lr_en_ff <= i_mode_uv_enable;
        end
    end

    always_comb begin
        status                     = '0;
        status.input_pin_level     = mon.aux_high;
        status.inverted_line_level = ~mon.line_high;
        status.line_fault_irq      = lf_irq_ff;
        status.low_rail_uv_irq     = lr_irq_ff;
        status.supply_uv_irq       = su_irq_ff;
        status.overtemp_irq        = ot_irq_ff;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_interrupt_out_n  <= 1'b1;
            o_undervoltage_out <= 1'b0;
            o_mode_flags       <= '0;
        end else begin
            // Line level is kept out of the interrupt on purpose
            o_interrupt_out_n  <= ~(lf_irq_ff
                                  | (lr_irq_ff & lr_en_ff)
                                  | su_irq_ff
                                  | ot_irq_ff);
            o_undervoltage_out <= lr_en_ff & mon.low_rail_uv;
            o_mode_flags <= {mon.line_fault, mon.supply_uv,
                             ot_flag_ff, lr_en_ff};
        end
    end

    // ------------------------------------------------------------
    // Line port receiver and driver control
    // ------------------------------------------------------------
    logic line_level;
    logic drv_en;
    logic drv_on;

    // Transmit low drives the line high; soft value matters when high
    assign line_level = ~(tx_a & tx_b) | cfg_ff.line_soft_value;
    assign drv_en     = cfg_ff.line_driver_force_enable | driver_enable_pin;
    assign drv_on     = cfg_ff.line_push_pull_select
                        | (cfg_ff.line_sink_source_select
                           ? ~line_level : line_level);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_line_out         <= 1'b0;
            o_line_oe          <= 1'b0;
            o_line_receive_out <= 1'b1;
            o_input_level_out  <= 1'b1;
            o_line_cfg         <= LTSC_LINE_CFG_RST;
        end else begin
            o_line_out         <= line_level;
            o_line_oe          <= drv_en & drv_on;
            o_line_receive_out <= cfg_ff.line_receiver_disable
                                  | ~mon.line_high;
            o_input_level_out  <= ~mon.aux_high;
            // Filter, slew and sink bits steer the analog side directly
            o_line_cfg         <= cfg_ff;
        end
    end

endmodule : ltsc_core

`default_nettype wire

/* File: tb/ltsc_mcu_model.sv */
// Microcontroller side of the serial register port.
// Assumes the caller runs frames one at a time from the bench clock.
`timescale 1ns/10ps
`default_nettype none
module ltsc_mcu_model (
    input  wire logic i_clk,
    output var  logic o_cs_n,
    output var  logic o_sclk,
    output var  logic o_sdi,
    input  wire logic i_sdo
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end

    // Six clocks per half period: sync lag on the design side is three
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
        rd = 8'h00;
        o_cs_n = 1'b0;
        repeat (6) @(negedge i_clk);
        for (int i = 15; i >= 0; i--) begin
            o_sdi = f[i];
            repeat (6) @(negedge i_clk);
            if (i < 8) begin
                rd = {rd[6:0], i_sdo};
            end
            o_sclk = 1'b1;
            repeat (6) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (6) @(negedge i_clk);
        o_cs_n = 1'b1;
        // Released data line must not keep its last bit
        o_sdi = ~o_sdi;
        repeat (8) @(negedge i_clk);
    endtask : xfer
endmodule : ltsc_mcu_model
`default_nettype wire

/* File: tb/ltsc_core_monitor.sv */
// Port checker for ltsc_core.
// Assumes pin inputs reach the checked outputs within four clocks.
`timescale 1ns/10ps
`default_nettype none
module ltsc_core_monitor
    import ltsc_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_reset_n,
    input wire logic             i_spi_cs_n,
    input wire logic             o_spi_sdo_oe,
    input wire logic             i_driver_enable_pin,
    input wire logic             i_transmit_input_a,
    input wire logic             i_transmit_input_b,
    input wire ltsc_mon_t        i_mon,
    input wire ltsc_mode_flags_t o_mode_flags,
    input wire ltsc_line_cfg_t   o_line_cfg,
    input wire logic             o_line_out,
    input wire logic             o_line_oe,
    input wire logic             o_line_receive_out,
    input wire logic             o_input_level_out,
    input wire logic             o_undervoltage_out,
    input wire logic             o_interrupt_out_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_rx_dis;
        o_line_cfg.line_receiver_disable [*2] |-> o_line_receive_out;
    endproperty
    a_rx_dis: assert property (p_rx_dis)
        else $error("receive out low while disabled");
    property p_rx_lvl;
        $stable(i_mon.line_high)[*4]
        |=> o_line_receive_out == (o_line_cfg.line_receiver_disable
                                   || !$past(i_mon.line_high));
    endproperty
    a_rx_lvl: assert property (p_rx_lvl)
        else $error("receive out wrong");
    property p_li;
        $stable(i_mon.aux_high)[*4]
        |=> o_input_level_out != $past(i_mon.aux_high);
    endproperty
    a_li: assert property (p_li)
        else $error("input level out wrong");
    property p_fault_irq;
        i_mon.line_fault[*4] |=> !o_interrupt_out_n;
    endproperty
    a_fault_irq: assert property (p_fault_irq)
        else $error("interrupt idle during line fault");
    property p_fault_flag;
        i_mon.line_fault[*4] |=> o_mode_flags.line_fault_flag;
    endproperty
    a_fault_flag: assert property (p_fault_flag)
        else $error("line fault flag missing");
    property p_uv_on;
        (i_mon.low_rail_uv && o_mode_flags.low_rail_uv_enable)[*4]
        |=> o_undervoltage_out == o_mode_flags.low_rail_uv_enable;
    endproperty
    a_uv_on: assert property (p_uv_on)
        else $error("undervoltage out missing");
    property p_uv_off;
        (!i_mon.low_rail_uv)[*4] |=> !o_undervoltage_out;
    endproperty
    a_uv_off: assert property (p_uv_off)
        else $error("undervoltage out stuck");
    property p_drv_off;
        (!i_driver_enable_pin)[*4]
        |=> !o_line_oe || o_line_cfg.line_driver_force_enable;
    endproperty
    a_drv_off: assert property (p_drv_off)
        else $error("line driven while disabled");
    property p_soft;
        (i_transmit_input_a && i_transmit_input_b)[*4]
        |=> o_line_out == o_line_cfg.line_soft_value;
    endproperty
    a_soft: assert property (p_soft)
        else $error("line level not soft value");
    property p_sdo_oe;
        $stable(i_spi_cs_n)[*4] |=> o_spi_sdo_oe != $past(i_spi_cs_n);
    endproperty
    a_sdo_oe: assert property (p_sdo_oe)
        else $error("serial output enable wrong");

    c_irq: cover property ($fell(o_interrupt_out_n));
    c_uv: cover property ($rose(o_undervoltage_out));
    c_oe: cover property ($rose(o_line_oe));
endmodule : ltsc_core_monitor

bind ltsc_core ltsc_core_monitor u_mon (
    .i_clk, .i_reset_n, .i_spi_cs_n, .o_spi_sdo_oe,
    .i_driver_enable_pin, .i_transmit_input_a,
    .i_transmit_input_b, .i_mon, .o_mode_flags, .o_line_cfg, .o_line_out,
    .o_line_oe, .o_line_receive_out, .o_input_level_out,
    .o_undervoltage_out, .o_interrupt_out_n
);
`default_nettype wire

/* File: tb/ltsc_core_tb_top.sv */
// Self-checking bench for ltsc_core through its serial port.
// Assumes the microcontroller model and bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module ltsc_core_tb_top
    import ltsc_pkg::*;
;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             cs_n, sclk, sdi, sdo, sdo_oe;
    logic             driver_enable_pin, txa, txb, mode_wr, mode_en;
    ltsc_mon_t        mon;
    ltsc_mode_flags_t flags;
    ltsc_line_cfg_t   cfg;
    logic             lout, loe, rxo, li, uvo, irq_n;
    logic [7:0]       d;
    int               mismatches = 0;
    int               compares = 0;
    logic [7:0]       pat [3] = '{8'hA5, 8'h5A, 8'h00};
    logic [7:0]       dc [7] = '{8'h1C, 8'h18, 8'h0C, 8'h08, 8'h28, 8'h2C,
                                 8'h14};
    logic [1:0]       de [7] = '{2'h3, 2'h1, 2'h3, 2'h0, 2'h1, 2'h2, 2'h2};

    always #2.5 clk = ~clk;

    ltsc_mcu_model u_mcu (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk),
                          .o_sdi(sdi), .i_sdo(sdo));
    ltsc_core DUT (.i_clk(clk), .i_reset_n(rst_n), .i_spi_cs_n(cs_n),
        .i_spi_sclk(sclk), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
        .o_spi_sdo_oe(sdo_oe), .i_driver_enable_pin(driver_enable_pin),
        .i_transmit_input_a(txa), .i_transmit_input_b(txb), .i_mon(mon),
        .i_mode_wr(mode_wr), .i_mode_uv_enable(mode_en),
        .o_mode_flags(flags), .o_line_cfg(cfg), .o_line_out(lout),
        .o_line_oe(loe), .o_line_receive_out(rxo), .o_input_level_out(li),
        .o_undervoltage_out(uvo), .o_interrupt_out_n(irq_n));

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        logic [7:0] x;
        u_mcu.xfer({1'b1, 5'h00, a, v}, x);
    endtask : wr
    task automatic stat(input logic [7:0] e);
        u_mcu.xfer({6'h00, LTSC_ADDR_STATUS, 8'h00}, d);
        chk8(d, e);
    endtask : stat
    task automatic settle;
        repeat (8) @(negedge clk);
    endtask : settle
    task automatic mode(input logic v);
        mode_en = v;
        mode_wr = 1'b1;
        @(negedge clk);
        mode_wr = 1'b0;
        settle();
    endtask : mode
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        {driver_enable_pin, txa, txb, mode_wr, mode_en} = 5'h00;
        mon = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        settle();
        chk8(cfg, LTSC_LINE_CFG_RST);
        chk1(sdo_oe, 1'b0);
        foreach (pat[i]) begin
            wr(LTSC_ADDR_LINE_CFG, pat[i]);
            u_mcu.xfer({6'h00, LTSC_ADDR_LINE_CFG, 8'h00}, d);
            chk8(d, pat[i]);
            chk8(cfg, pat[i]);
        end
        wr(2'h2, 8'hFF);
        u_mcu.xfer({6'h00, 2'h2, 8'h00}, d);
        chk8(d, LTSC_READ_ZERO);
        chk8(cfg, 8'h00);
        mon.line_high = 1'b1;
        mon.aux_high = 1'b1;
        settle();
        stat(8'h20);
        chk1(li, 1'b0);
        chk1(rxo, 1'b0);
        mon.line_high = 1'b0;
        mon.aux_high = 1'b0;
        settle();
        stat(8'h10);
        stat(8'h10);
        chk1(li, 1'b1);
        wr(LTSC_ADDR_LINE_CFG, 8'h02);
        mon.line_high = 1'b1;
        settle();
        chk1(rxo, 1'b1);
        stat(8'h00);
        mon.line_fault = 1'b1;
        settle();
        chk1(irq_n, 1'b0);
        chk1(flags.line_fault_flag, 1'b1);
        stat(8'h08);
        stat(8'h08);
        mon.line_fault = 1'b0;
        stat(8'h08);
        stat(8'h00);
        chk1(irq_n, 1'b1);
        mon.supply_uv = 1'b1;
        settle();
        chk1(irq_n, 1'b0);
        chk1(flags.supply_uv_flag, 1'b1);
        stat(8'h02);
        stat(8'h00);
        chk1(irq_n, 1'b1);
        mon.supply_uv = 1'b0;
        mon.low_rail_uv = 1'b1;
        settle();
        chk1(flags.low_rail_uv_enable, 1'b1);
        chk1(uvo, 1'b1);
        chk1(irq_n, 1'b0);
        mode(1'b0);
        chk1(irq_n, 1'b1);
        stat(8'h04);
        stat(8'h00);
        mode(1'b1);
        chk1(uvo, 1'b1);
        mon.low_rail_uv = 1'b0;
        settle();
        chk1(uvo, 1'b0);
        mon.temp_hot = 1'b1;
        settle();
        chk1(flags.overtemp_flag, 1'b1);
        chk1(irq_n, 1'b0);
        stat(8'h01);
        stat(8'h00);
        chk1(irq_n, 1'b1);
        mon.temp_hot = 1'b0;
        settle();
        mon.temp_hot = 1'b1;
        stat(8'h00);
        {mon.temp_hot, mon.temp_cool} = 2'h1;
        settle();
        {mon.temp_hot, mon.temp_cool} = 2'h2;
        stat(8'h01);
        {txa, txb} = 2'h3;
        foreach (dc[i]) begin
            wr(LTSC_ADDR_LINE_CFG, dc[i]);
            chk8({6'h00, lout, loe},
                 {6'h00, de[i]});
        end
        driver_enable_pin = 1'b1;
        wr(LTSC_ADDR_LINE_CFG, 8'h10);
        chk8({6'h00, lout, loe}, 8'h01);
        txa = 1'b0;
        settle();
        chk8({6'h00, lout, loe}, 8'h03);
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule : ltsc_core_tb_top
`default_nettype wire
